// ### rtl/umd_pkg.sv
// Purpose: constants and carriers for the rs-485 multidrop and direction control block
// Assumes: apb with 32-bit data, one clock
// Notes: byte addresses, one aligned word per register
package umd_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_EXTRA_FEATURES = 8'h00;
  localparam logic [7:0] ADDR_ENHANCED = 8'h04;
  localparam logic [7:0] ADDR_SECOND_XOFF = 8'h08;
  localparam logic [7:0] ADDR_LINE_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int EF_IRDA_QUARTER = 7;
  localparam int EF_DIR_INVERT = 5;
  localparam int EF_TX_DRIVES_DIR = 4;
  localparam int EF_TX_OFF = 2;
  localparam int EF_RX_OFF = 1;
  localparam int EF_NINE_BIT = 0;
  localparam logic [7:0] EF_WRITABLE = 8'hb7;
  localparam int ENH_AUTO_FLOW_RTS = 6;
  localparam int ENH_SPECIAL_DETECT = 5;
  localparam int IER_LINE_STATUS = 2;
  localparam int MCR_MANUAL_RTS = 1;
  localparam int ST_RTS_LEVEL = 0;
  localparam int ST_TRANSMITTING = 1;
  localparam int ST_RX_ENABLED = 2;
  localparam int ST_TX_ENABLED = 3;

  // ************************************************************
  // events
  // ************************************************************
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_ADDR_ACCEPT = 0;
  localparam int IRQ_ADDR_REJECT = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_LINE_STATUS = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_EXTRA_FEATURES = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [IRQ_WIDTH-1:0] RST_IRQ = 4'h0;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic parity_error;
  } umd_char_type;

endpackage : umd_pkg

// ### rtl/umd_rs485_control.sv
// Purpose: extra-features control of one uart channel: infrared pulse select, tx/rx disable,
//          automatic rs-485 direction over rts, 9-bit multidrop address handling
// Assumes: apb slave on pclk; uart shifters and fifos on the same clock
// Notes: the shifter only stops loading new characters while the transmitter is off
// How it works
// R01: ef bit 7 picks infrared pulse: 0 is 3/16, 1 is 1/4.
// R02: ef bit 5 inverts rts level while direction mode transmits or receives.
// R03: ef bit 4 hands rts to transmitter, over manual and flow control.
// R04: rts asserts on host fifo write, releases after last bit leaves.
// R05: software turns hardware flow control off before direction mode.
// R06: ef bit 2 stops sending; fifo still fills; current character completes.
// R07: ef bit 1 stops receiving now, partial shift content flushed to fifo.
// R08: ef bit 0 selects multidrop 9-bit mode; ninth bit marks addresses.
// R09: software sets forced parity 0 and no special detect for plain multidrop.
// R10: plain multidrop, receiver off: drop ninth-bit-0 characters, await an address.
// R11: address character pushed with parity error, line status event if enabled.
// R12: controller enables receiver only when address equals its own identifier.
// R13: enabled receiver takes data; next address flagged parity error again.
// R14: auto detect drops data and non-matching addresses while waiting.
// R15: matching address enables receiver, pushed with ninth bit as error flag.
// R16: non-matching address while enabled disables receiver, character dropped.
// R17: reserved ef bits 6 and 3 read zero, writes ignored.
module umd_rs485_control
  import umd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_fifo_write,
  input wire logic tx_all_sent,
  output logic tx_load_allow,
  input wire logic flow_rts_n,
  output logic rts_n,
  input wire umd_char_type rx_char,
  input wire logic rx_char_valid,
  output umd_char_type rx_push_char,
  output logic rx_push,
  output logic rx_enabled,
  output logic rx_flush,
  output logic line_status_event,
  output logic irda_quarter_pulse,
  output logic [7:0] line_control,
  output logic irq
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] extra_features_control_reg;
  logic [7:0] extra_features_control_next;
  logic [7:0] enhanced_reg;
  logic [7:0] second_xoff_reg;
  logic [7:0] line_control_reg;
  logic [7:0] int_enable_reg;
  logic [7:0] modem_control_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic transmitting_reg;
  logic tx_all_sent_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  umd_char_type rx_push_char_reg;
  logic rx_push_reg;
  logic rx_flush_reg;
  logic line_status_event_reg;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire logic setup_phase = psel & ~penable;
  wire logic wr_done = psel & penable & pwrite;
  wire logic [7:0] addr_low = paddr[7:0];
  wire logic addr_upper_zero = (paddr[31:8] == 24'h000000);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr, input logic upper_zero);
    hit = upper_zero & (a == reg_addr);
  endfunction : hit

  wire logic hit_ef = hit(addr_low, ADDR_EXTRA_FEATURES, addr_upper_zero);
  wire logic hit_enh = hit(addr_low, ADDR_ENHANCED, addr_upper_zero);
  wire logic hit_xoff = hit(addr_low, ADDR_SECOND_XOFF, addr_upper_zero);
  wire logic hit_lcr = hit(addr_low, ADDR_LINE_CONTROL, addr_upper_zero);
  wire logic hit_ier = hit(addr_low, ADDR_INT_ENABLE, addr_upper_zero);
  wire logic hit_mcr = hit(addr_low, ADDR_MODEM_CONTROL, addr_upper_zero);
  wire logic hit_state = hit(addr_low, ADDR_STATE, addr_upper_zero);
  wire logic hit_irqs = hit(addr_low, ADDR_IRQ_STATUS, addr_upper_zero);
  wire logic hit_irqm = hit(addr_low, ADDR_IRQ_MASK, addr_upper_zero);
  wire logic hit_any = hit_ef | hit_enh | hit_xoff | hit_lcr | hit_ier | hit_mcr | hit_state | hit_irqs | hit_irqm;

  // ************************************************************
  // write strobes
  // ************************************************************
  // state register is read only, so it has no strobe
  wire logic wr_ef = wr_done & hit_ef;
  wire logic wr_enh = wr_done & hit_enh;
  wire logic wr_xoff = wr_done & hit_xoff;
  wire logic wr_lcr = wr_done & hit_lcr;
  wire logic wr_ier = wr_done & hit_ier;
  wire logic wr_mcr = wr_done & hit_mcr;
  wire logic wr_irqm = wr_done & hit_irqm;

  // ************************************************************
  // mode fields
  // ************************************************************
  wire logic nine_bit_mode = extra_features_control_reg[EF_NINE_BIT]; // [R08]
  wire logic receiver_off = extra_features_control_reg[EF_RX_OFF];
  wire logic transmitter_off = extra_features_control_reg[EF_TX_OFF];
  wire logic tx_drives_dir = extra_features_control_reg[EF_TX_DRIVES_DIR];
  wire logic dir_invert = extra_features_control_reg[EF_DIR_INVERT];
  wire logic special_detect = enhanced_reg[ENH_SPECIAL_DETECT];
  wire logic auto_flow_rts = enhanced_reg[ENH_AUTO_FLOW_RTS];
  wire logic line_irq_on = int_enable_reg[IER_LINE_STATUS];

  // ************************************************************
  // receive filter
  // ************************************************************
  wire logic is_address = rx_char_valid & nine_bit_mode & rx_char.ninth;
  wire logic is_data = rx_char_valid & ~(nine_bit_mode & rx_char.ninth);
  wire logic addr_match = (rx_char.data == second_xoff_reg);
  wire logic auto_detect = nine_bit_mode & special_detect;
  // plain multidrop: every address goes to the fifo flagged as parity error
  wire logic plain_addr_push = is_address & ~auto_detect; // [R11] [R13]

  // ************************************************************
  // auto address detection
  // ************************************************************
  // only the programmed address passes; a miss while enabled turns the receiver off
  wire logic auto_addr_accept = is_address & auto_detect & addr_match; // [R15]
  wire logic auto_addr_reject = is_address & auto_detect & ~addr_match & ~receiver_off; // [R16]

  // ************************************************************
  // push decision
  // ************************************************************
  // data passes only while the receiver is on, otherwise dropped
  wire logic data_push = is_data & ~receiver_off; // [R10] [R14]
  wire logic push_now = plain_addr_push | auto_addr_accept | data_push;
  wire logic push_perr = (plain_addr_push | auto_addr_accept) ? 1'b1 : rx_char.parity_error; // [R11] [R15]
  wire logic line_event_now = push_now & push_perr & line_irq_on; // [R11] [R15]

  // ************************************************************
  // extra features register update
  // ************************************************************
  // hardware enable/disable of the receiver wins over a software write in the same cycle
  always_comb begin
    extra_features_control_next = extra_features_control_reg;
    if (wr_ef) begin
      extra_features_control_next = pwdata[7:0] & EF_WRITABLE; // [R17]
    end
    if (auto_addr_accept) begin
      extra_features_control_next[EF_RX_OFF] = 1'b0; // [R15]
    end else if (auto_addr_reject) begin
      extra_features_control_next[EF_RX_OFF] = 1'b1; // [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_features_control_reg <= RST_EXTRA_FEATURES;
    end else begin
      extra_features_control_reg <= extra_features_control_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enhanced_reg <= RST_BYTE;
    end else if (wr_enh) begin
      enhanced_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_xoff_reg <= RST_BYTE;
    end else if (wr_xoff) begin
      second_xoff_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_control_reg <= RST_BYTE;
    end else if (wr_lcr) begin
      line_control_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_reg <= RST_BYTE;
    end else if (wr_ier) begin
      int_enable_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control_reg <= RST_BYTE;
    end else if (wr_mcr) begin
      modem_control_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= RST_IRQ;
    end else if (wr_irqm) begin
      irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  // ************************************************************
  // receive outputs
  // ************************************************************
  // rising edge of the disable bit asks the deserializer to flush its partial character
  wire logic rx_off_rise = extra_features_control_next[EF_RX_OFF] & ~receiver_off; // [R07]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_push_reg <= 1'b0;
      rx_push_char_reg <= '0;
      rx_flush_reg <= 1'b0;
      line_status_event_reg <= 1'b0;
    end else begin
      rx_push_reg <= push_now;
      rx_flush_reg <= rx_off_rise; // [R07]
      line_status_event_reg <= line_event_now;
      if (push_now) begin
        rx_push_char_reg <= '{data: rx_char.data, ninth: rx_char.ninth, parity_error: push_perr};
      end
    end
  end

  // ************************************************************
  // direction control
  // ************************************************************
  // transmitting from the host write until the line reports the last bit gone
  wire logic tx_done_now = tx_all_sent & ~tx_all_sent_reg & transmitting_reg & ~tx_fifo_write;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmitting_reg <= 1'b0;
      tx_all_sent_reg <= 1'b1;
    end else begin
      tx_all_sent_reg <= tx_all_sent;
      if (tx_fifo_write) begin
        transmitting_reg <= 1'b1; // [R04]
      end else if (tx_done_now) begin
        transmitting_reg <= 1'b0; // [R04]
      end
    end
  end

  // direction level: low while sending unless inverted
  wire logic dir_level = transmitting_reg ^ ~dir_invert; // [R02] [R04]
  wire logic manual_rts_n = ~modem_control_reg[MCR_MANUAL_RTS];
  // without direction mode the flow logic owns rts when enabled, else the manual bit
  wire logic undirected_rts_n = auto_flow_rts ? flow_rts_n : manual_rts_n; // [R03]
  wire logic rts_sel = tx_drives_dir ? dir_level : undirected_rts_n; // [R03] [R05]

  // ************************************************************
  // interrupt status
  // ************************************************************
  // events per bit: address taken, address refused, send done, line status
  logic [IRQ_WIDTH-1:0] irq_event;
  assign irq_event[IRQ_ADDR_ACCEPT] = plain_addr_push | auto_addr_accept;
  assign irq_event[IRQ_ADDR_REJECT] = auto_addr_reject;
  assign irq_event[IRQ_TX_DONE] = tx_done_now;
  assign irq_event[IRQ_LINE_STATUS] = line_event_now;
  wire logic irq_clear_wr = wr_done & hit_irqs;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_WIDTH; gi++) begin : g_irq
      // a new event wins over a write-one clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_status_reg[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_status_reg[gi] <= 1'b1;
        end else if (irq_clear_wr && pwdata[gi]) begin
          irq_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] read_mux;
  wire logic [7:0] state_word = {4'h0, ~transmitter_off, ~receiver_off, transmitting_reg, rts_n};

  always_comb begin
    read_mux = 32'h00000000;
    unique case (1'b1)
      hit_ef: read_mux[7:0] = extra_features_control_reg; // [R17]
      hit_enh: read_mux[7:0] = enhanced_reg;
      hit_xoff: read_mux[7:0] = second_xoff_reg;
      hit_lcr: read_mux[7:0] = line_control_reg;
      hit_ier: read_mux[7:0] = int_enable_reg;
      hit_mcr: read_mux[7:0] = modem_control_reg;
      hit_state: read_mux[7:0] = state_word;
      hit_irqs: read_mux[IRQ_WIDTH-1:0] = irq_status_reg;
      hit_irqm: read_mux[IRQ_WIDTH-1:0] = irq_mask_reg;
      default: read_mux = 32'h00000000;
    endcase
  end

  // read data and error are caught in the setup cycle, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? 32'h00000000 : read_mux;
      pslverr_reg <= ~hit_any;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = prdata_reg;
  assign pready = psel & penable;
  assign pslverr = psel & penable & pslverr_reg;
  assign tx_load_allow = ~transmitter_off; // [R06]
  assign rts_n = rts_sel;
  assign rx_push_char = rx_push_char_reg;
  assign rx_push = rx_push_reg;
  assign rx_enabled = ~receiver_off; // [R07]
  assign rx_flush = rx_flush_reg;
  assign line_status_event = line_status_event_reg;
  assign irda_quarter_pulse = extra_features_control_reg[EF_IRDA_QUARTER]; // [R01]
  assign line_control = line_control_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule : umd_rs485_control

// ### verif/umd_assertions.sv
// Purpose: port checks of umd_rs485_control
// Assumes: shadow copies follow apb writes to mapped registers
// Notes: one clock domain
module umd_checker
  import umd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic tx_fifo_write,
  input wire logic tx_all_sent,
  input wire logic tx_load_allow,
  input wire logic flow_rts_n,
  input wire logic rts_n,
  input wire umd_char_type rx_char,
  input wire logic rx_char_valid,
  input wire umd_char_type rx_push_char,
  input wire logic rx_push,
  input wire logic rx_enabled,
  input wire logic rx_flush,
  input wire logic line_status_event,
  input wire logic irda_quarter_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // shadows and properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ef_reg, enh_reg, xoff_reg, mcr_reg, ier_reg;
  wire logic wr = psel && penable && pwrite && paddr[31:8] == 24'h0;
  wire logic [7:0] wa = paddr[7:0];
  wire logic auto_addr = rx_char_valid && ef_reg[0] && enh_reg[5] && rx_char.ninth;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ef_reg, enh_reg, xoff_reg, mcr_reg, ier_reg} <= 40'h0;
    end else if (wr) begin
      if (wa == ADDR_EXTRA_FEATURES) ef_reg <= pwdata[7:0] & EF_WRITABLE;
      if (wa == ADDR_ENHANCED) enh_reg <= pwdata[7:0];
      if (wa == ADDR_SECOND_XOFF) xoff_reg <= pwdata[7:0];
      if (wa == ADDR_MODEM_CONTROL) mcr_reg <= pwdata[7:0];
      if (wa == ADDR_INT_ENABLE) ier_reg <= pwdata[7:0];
    end
  end
  AST_IRDA_SEL: assert property (irda_quarter_pulse == ef_reg[7]) else $error("pulse select wrong");
  AST_TX_GATE: assert property (tx_load_allow == !ef_reg[2]) else $error("tx gate wrong");
  AST_RX_FLUSH: assert property ($fell(rx_enabled) && !$past(rx_char_valid) |-> ##[0:1] rx_flush)
    else $error("no flush");
  AST_DIR_ON: assert property (tx_fifo_write && ef_reg[4] |=> rts_n == ef_reg[5])
    else $error("direction not taken");
  AST_DIR_OFF: assert property (ef_reg[4] && $rose(tx_all_sent) && !tx_fifo_write |=> rts_n == !ef_reg[5])
    else $error("direction not released");
  AST_RTS_MUX: assert property (!ef_reg[4] |-> rts_n == (enh_reg[6] ? flow_rts_n : !mcr_reg[1]))
    else $error("rts source wrong");
  AST_PLAIN_ADDR: assert property (rx_char_valid && ef_reg[0] && !enh_reg[5] && rx_char.ninth
    |=> rx_push && rx_push_char.parity_error) else $error("address not flagged");
  AST_DROP_DATA: assert property (rx_char_valid && ef_reg[0] && !rx_enabled && !rx_char.ninth |=> !rx_push)
    else $error("data not dropped");
  AST_AUTO_MISS: assert property (auto_addr && rx_char.data != xoff_reg |=> !rx_push && !rx_enabled)
    else $error("miss not dropped");
  AST_AUTO_HIT: assert property (auto_addr && rx_char.data == xoff_reg
    |=> rx_push && rx_enabled && rx_push_char.data == $past(rx_char.data)) else $error("hit not taken");
  AST_LSE: assert property (rx_push |-> line_status_event == (rx_push_char.parity_error && ier_reg[2]))
    else $error("line status event wrong");
  cover property (auto_addr && rx_char.data == xoff_reg);
  cover property (ef_reg[4] && $rose(tx_all_sent));
  cover property (rx_push && line_status_event);
endmodule : umd_checker

bind umd_rs485_control umd_checker i_umd_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_fifo_write(tx_fifo_write),
  .tx_all_sent(tx_all_sent), .tx_load_allow(tx_load_allow), .flow_rts_n(flow_rts_n), .rts_n(rts_n),
  .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_push_char(rx_push_char), .rx_push(rx_push),
  .rx_enabled(rx_enabled), .rx_flush(rx_flush), .line_status_event(line_status_event),
  .irda_quarter_pulse(irda_quarter_pulse));

// ### verif/umd_station.sv
// Purpose: line-side model, shifter drain and received characters
// Assumes: characters arrive already deserialized
// Notes: rx_char shows inverted data outside its valid cycle
module umd_station
  import umd_pkg::*;
#(
  parameter int SHIFT_CYCLES = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_fifo_write,
  input wire logic tx_load_allow,
  output logic tx_all_sent,
  output umd_char_type rx_char,
  output logic rx_char_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // shifter and sender
  // ****************************************
  int pending_reg, shift_reg;
  wire logic load = pending_reg != 0 && shift_reg == 0 && tx_load_allow;
  assign tx_all_sent = pending_reg == 0 && shift_reg == 0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 0;
      shift_reg <= 0;
    end else begin
      pending_reg <= pending_reg + (tx_fifo_write ? 1 : 0) - (load ? 1 : 0);
      shift_reg <= load ? SHIFT_CYCLES : (shift_reg != 0 ? shift_reg - 1 : 0);
    end
  end
  initial begin
    rx_char = '0;
    rx_char_valid = 1'b0;
  end
  // forced parity 0 flags every address as a parity error
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge pclk);
    rx_char <= '{data: d, ninth: n, parity_error: n};
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~rx_char;
  endtask : send
endmodule : umd_station

// ### verif/tb.sv
// Purpose: register and line scenarios for umd_rs485_control
// Assumes: zero wait apb, partner model on the line side
// Notes: self-checking
module tb
  import umd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bench
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, tx_fifo_write, flow_rts_n, err_seen;
  logic [31:0] paddr, pwdata, prdata, q;
  logic pready, pslverr, tx_all_sent, tx_load_allow, rts_n, rx_char_valid, rx_push, rx_enabled;
  logic rx_flush, line_status_event, irda_quarter_pulse, irq;
  logic [7:0] line_control;
  umd_char_type rx_char, rx_push_char;
  int error_cnt = 0;
  int compares = 0;
  umd_rs485_control i_umd_rs485_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_write(tx_fifo_write), .tx_all_sent(tx_all_sent), .tx_load_allow(tx_load_allow),
    .flow_rts_n(flow_rts_n), .rts_n(rts_n), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_push_char(rx_push_char), .rx_push(rx_push), .rx_enabled(rx_enabled), .rx_flush(rx_flush),
    .line_status_event(line_status_event), .irda_quarter_pulse(irda_quarter_pulse),
    .line_control(line_control), .irq(irq));
  umd_station i_umd_station (.pclk(pclk), .presetn(presetn), .tx_fifo_write(tx_fifo_write),
    .tx_load_allow(tx_load_allow), .tx_all_sent(tx_all_sent), .rx_char(rx_char), .rx_char_valid(rx_char_valid));
  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask : rd
  task automatic rx(input logic [7:0] d, input logic n, input logic push, input logic en);
    i_umd_station.send(d, n);
    #1;
    chk("rx_push", rx_push, push);
    chk("rx_enabled", rx_enabled, en);
    if (push) chk("rx_push_char", rx_push_char, {d, n, n});
    if (push) chk("line_status_event", line_status_event, n);
  endtask : rx
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, tx_fifo_write, presetn, paddr, pwdata} = '0;
    flow_rts_n = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("extra_features", ADDR_EXTRA_FEATURES, 32'h0);
    chk("rts_n", rts_n, 1'b1);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'hff);
    chk("rx_flush", rx_flush, 1'b1);
    rd("extra_features", ADDR_EXTRA_FEATURES, 32'hb7);
    chk("irda_quarter_pulse", irda_quarter_pulse, 1'b1);
    chk("tx_load_allow", tx_load_allow, 1'b0);
    chk("rx_enabled", rx_enabled, 1'b0);
    apb(1'b1, ADDR_INT_ENABLE, 32'h4);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h0);
    chk("irda_quarter_pulse", irda_quarter_pulse, 1'b0);
    rx(8'h77, 1'b1, 1'b1, 1'b1);
    rd("unmapped", 8'h40, 32'h0);
    chk("pslverr", err_seen, 1'b1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    for (int inv = 0; inv < 2; inv++) begin
      apb(1'b1, ADDR_EXTRA_FEATURES, inv ? 32'h30 : 32'h10);
      @(posedge pclk) tx_fifo_write <= 1'b1;
      @(posedge pclk) tx_fifo_write <= 1'b0;
      repeat (5) @(posedge pclk);
      #1;
      chk("rts_n", rts_n, inv[0]);
      while (tx_all_sent !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      #1;
      chk("rts_n", rts_n, !inv[0]);
      chk("irq", irq, 1'b1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
      chk("irq", irq, 1'b0);
    end
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h0);
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h2);
    chk("rts_n", rts_n, 1'b0);
    apb(1'b1, ADDR_ENHANCED, 32'h40);
    chk("rts_n", rts_n, 1'b1);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h30);
    chk("rts_n", rts_n, 1'b0);
    apb(1'b1, ADDR_ENHANCED, 32'h0);
    apb(1'b1, ADDR_LINE_CONTROL, 32'h38);
    chk("line_control", line_control, 8'h38);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h3);
    rx(8'h11, 1'b0, 1'b0, 1'b0);
    rx(8'h42, 1'b1, 1'b1, 1'b0);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h1);
    rx(8'h55, 1'b0, 1'b1, 1'b1);
    rx(8'h43, 1'b1, 1'b1, 1'b1);
    apb(1'b1, ADDR_EXTRA_FEATURES, 32'h3);
    apb(1'b1, ADDR_IRQ_STATUS, 32'hf);
    apb(1'b1, ADDR_SECOND_XOFF, 32'h5a);
    apb(1'b1, ADDR_ENHANCED, 32'h20);
    rx(8'h5a, 1'b0, 1'b0, 1'b0);
    rx(8'h33, 1'b1, 1'b0, 1'b0);
    rx(8'h5a, 1'b1, 1'b1, 1'b1);
    rx(8'h66, 1'b0, 1'b1, 1'b1);
    rx(8'h33, 1'b1, 1'b0, 1'b0);
    rd("irq_status", ADDR_IRQ_STATUS, 32'hb);
    give_verdict();
  end
endmodule : tb
